/* File: hw/jtb_cfg.svh */
// constants for the boundary scan test access port
// assumes inclusion by jtb_pkg and jtb_tap only
`ifndef JTB_CFG_SVH
`define JTB_CFG_SVH
// instruction register
`define JTB_IR_W 8
`define JTB_OP_EXTEST 8'h00
`define JTB_OP_SAMPLE 8'h01
`define JTB_OP_CLAMP 8'h05
`define JTB_OP_HIGHZ 8'h07
`define JTB_OP_USERCODE 8'h0E
`define JTB_OP_IDCODE 8'h0F
`define JTB_OP_BYPASS 8'hFF
`define JTB_IR_CAPT 8'h01
// identification word layout
`define JTB_ID_W 32
`define JTB_ID_LSB 1'h1
`define JTB_ID_MFR_W 11
`define JTB_ID_PART_W 16
`define JTB_ID_VER_W 4
// cells per i/o and their offsets in the chain
`define JTB_CELLS 3
`define JTB_CELL_IN 0
`define JTB_CELL_OUT 1
`define JTB_CELL_OE 2
// tap state encodings, gray along the usual path
`define JTB_S_TLR 4'h0
`define JTB_S_RTI 4'h1
`define JTB_S_SDR 4'h3
`define JTB_S_CDR 4'h2
`define JTB_S_SHDR 4'h6
`define JTB_S_E1DR 4'h7
`define JTB_S_PDR 4'h5
`define JTB_S_E2DR 4'h4
`define JTB_S_UDR 4'hC
`define JTB_S_SIR 4'hD
`define JTB_S_CIR 4'hF
`define JTB_S_SHIR 4'hE
`define JTB_S_E1IR 4'hA
`define JTB_S_PIR 4'hB
`define JTB_S_E2IR 4'h9
`define JTB_S_UIR 4'h8
// fifo
`define JTB_FIFO_DEPTH 16
`endif

/* File: hw/jtb_pkg.sv */
// types for the boundary scan test access port
// assumes jtb_cfg.svh on the include path
`include "jtb_cfg.svh"
package jtb_pkg;
  // tap controller states
  typedef enum logic [3:0] {
    JTB_TLR = `JTB_S_TLR, JTB_RTI = `JTB_S_RTI,
    JTB_SDR = `JTB_S_SDR, JTB_CDR = `JTB_S_CDR,
    JTB_SHDR = `JTB_S_SHDR, JTB_E1DR = `JTB_S_E1DR,
    JTB_PDR = `JTB_S_PDR, JTB_E2DR = `JTB_S_E2DR,
    JTB_UDR = `JTB_S_UDR, JTB_SIR = `JTB_S_SIR,
    JTB_CIR = `JTB_S_CIR, JTB_SHIR = `JTB_S_SHIR,
    JTB_E1IR = `JTB_S_E1IR, JTB_PIR = `JTB_S_PIR,
    JTB_E2IR = `JTB_S_E2IR, JTB_UIR = `JTB_S_UIR
  } jtb_state_e;
  // data register selected by an opcode
  typedef enum logic [1:0] {
    JTB_DR_BYP = 2'h0,
    JTB_DR_ID = 2'h1,
    JTB_DR_BSR = 2'h2
  } jtb_dr_e;
  // the three serial-side jtag inputs
  typedef struct packed {
    logic tms;
    logic tdi;
    logic trst_n;
  } jtb_jtag_s;
endpackage

/* File: hw/jtb_tap.sv */
// boundary scan tap with fifo of applied update words
// assumes tck_in runs from an external controller; pads are async pins
//
// Behaviour
// - unprogrammed device keeps all user i/o disabled
// - sample cannot turn on unprogrammed input buffers
// - extest, sample/preload, bypass and idcode present
// - undriven tms, tdi, trst read high
// - sixteen-state four-bit tap controller drives test logic
// - tms on rising tck decides every transition
// - power-up puts tap in test-logic-reset
// - five tms-high edges reach test-logic-reset
// - low trst resets tap asynchronously
// - bypass, id, boundary registers; id is selected after reset, bypass for unknown opcodes
// - id word holds lsb, maker, part, version
// - three cells per i/o: in, out, enable
// - one chain from tdi to tdo
// - cells sit between core and pad buffers
// - opcodes extest 00, sample 01, bypass ff
// - idcode 0f, usercode 0e, highz 07, clamp 05
`timescale 1ns/1ns
`include "jtb_cfg.svh"

// ****************************************
// fifo
// ****************************************
module jtb_fifo #(
  parameter int W = 8,
  parameter int D = `JTB_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D]; // storage
  logic [AW-1:0] wr_reg; // write pointer
  logic [AW-1:0] rd_reg; // read pointer
  logic [AW:0] cnt_reg; // words held
  logic push; // accepted write
  logic pop; // accepted read
  if (D < 2 || (1 << AW) != D) $error("fifo depth must be power of two");
  assign in_ready_out = cnt_reg != D[AW:0];
  assign out_valid_out = cnt_reg != '0;
  assign out_data_out = mem_reg[rd_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  // storage write
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data_in;
  end
  // pointers and level
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ****************************************
// tap top
// ****************************************
module jtb_tap #(
  parameter int N_IO = 4, // user i/o count
  parameter logic [`JTB_ID_MFR_W-1:0] ID_MFR = 11'h000, // arbitrary
  parameter logic [`JTB_ID_PART_W-1:0] ID_PART = 16'h0000, // arbitrary
  parameter logic [`JTB_ID_VER_W-1:0] ID_VER = 4'h0, // arbitrary
  parameter logic [`JTB_ID_W-1:0] USER_CODE = 32'h0000_0000
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic tck_in,
  input wire jtb_pkg::jtb_jtag_s jtag_in,
  input wire jtb_pkg::jtb_jtag_s jtag_float_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  input wire logic programmed_in,
  input wire logic [N_IO-1:0] pad_in,
  output logic [N_IO-1:0] pad_out,
  output logic [N_IO-1:0] pad_oe_out,
  output logic [N_IO-1:0] core_in_out,
  input wire logic [N_IO-1:0] core_out_in,
  input wire logic [N_IO-1:0] core_oe_in,
  output logic obs_valid_out,
  input wire logic obs_ready_in,
  output logic [2*N_IO-1:0] obs_data_out
);
  import jtb_pkg::*;
  localparam int NC = `JTB_CELLS * N_IO; // chain length
  if (N_IO < 1) $error("need at least one i/o");

  // ****************************************
  // decode
  // ****************************************
  // opcode to data register; unknown opcodes pick bypass
  function automatic jtb_dr_e dr_of(input logic [`JTB_IR_W-1:0] op);
    case (op)
      `JTB_OP_EXTEST, `JTB_OP_SAMPLE: dr_of = JTB_DR_BSR;
      `JTB_OP_IDCODE, `JTB_OP_USERCODE: dr_of = JTB_DR_ID;
      default: dr_of = JTB_DR_BYP;
    endcase
  endfunction

  // ****************************************
  // tck domain
  // ****************************************
  jtb_jtag_s pin; // pins with pull-ups applied
  logic tap_rst; // power-up or trst
  jtb_state_e st_reg; // tap state
  jtb_state_e st_next; // next tap state
  logic [`JTB_IR_W-1:0] ir_sh_reg; // ir shift stage
  logic [`JTB_IR_W-1:0] ir_reg; // current opcode
  logic byp_reg; // bypass stage
  logic [`JTB_ID_W-1:0] id_reg; // id / usercode shifter
  logic [NC-1:0] bsr_reg; // boundary chain shifter
  logic [NC-1:0] upd_reg; // boundary update latches
  logic upd_tog_reg; // toggles on each boundary update
  logic drive_reg; // pads from update latches
  logic hiz_reg; // all pads off
  logic [NC-1:0] cap_s1_reg; // pin state, first stage
  logic [NC-1:0] cap_s2_reg; // pin state, second stage
  logic [NC-1:0] pin_view; // pin state in chain order
  jtb_dr_e dr_sel; // current data register

  assign pin = jtag_in | jtag_float_in;
  assign tap_rst = sys_rst_in || !pin.trst_n;
  assign dr_sel = dr_of(ir_reg);

  // tap next state from tms
  always_comb
  begin
    case (st_reg)
      JTB_TLR: st_next = pin.tms ? JTB_TLR : JTB_RTI;
      JTB_RTI: st_next = pin.tms ? JTB_SDR : JTB_RTI;
      JTB_SDR: st_next = pin.tms ? JTB_SIR : JTB_CDR;
      JTB_CDR: st_next = pin.tms ? JTB_E1DR : JTB_SHDR;
      JTB_SHDR: st_next = pin.tms ? JTB_E1DR : JTB_SHDR;
      JTB_E1DR: st_next = pin.tms ? JTB_UDR : JTB_PDR;
      JTB_PDR: st_next = pin.tms ? JTB_E2DR : JTB_PDR;
      JTB_E2DR: st_next = pin.tms ? JTB_UDR : JTB_SHDR;
      JTB_UDR: st_next = pin.tms ? JTB_SDR : JTB_RTI;
      JTB_SIR: st_next = pin.tms ? JTB_TLR : JTB_CIR;
      JTB_CIR: st_next = pin.tms ? JTB_E1IR : JTB_SHIR;
      JTB_SHIR: st_next = pin.tms ? JTB_E1IR : JTB_SHIR;
      JTB_E1IR: st_next = pin.tms ? JTB_UIR : JTB_PIR;
      JTB_PIR: st_next = pin.tms ? JTB_E2IR : JTB_PIR;
      JTB_E2IR: st_next = pin.tms ? JTB_UIR : JTB_SHIR;
      JTB_UIR: st_next = pin.tms ? JTB_SDR : JTB_RTI;
      default: st_next = JTB_TLR;
    endcase
  end

  // tap state register
  always_ff @(posedge tck_in or posedge tap_rst)
  begin
    if (tap_rst)
      st_reg <= JTB_TLR;
    else
      st_reg <= st_next;
  end

  // instruction register
  always_ff @(posedge tck_in or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      ir_sh_reg <= `JTB_IR_CAPT;
      ir_reg <= `JTB_OP_IDCODE;
    end
    else
    begin
      case (st_reg)
        JTB_TLR: ir_reg <= `JTB_OP_IDCODE;
        JTB_CIR: ir_sh_reg <= `JTB_IR_CAPT;
        JTB_SHIR: ir_sh_reg <= {pin.tdi, ir_sh_reg[`JTB_IR_W-1:1]};
        JTB_UIR: ir_reg <= ir_sh_reg;
        default: ir_sh_reg <= ir_sh_reg;
      endcase
    end
  end

  // pad mode flags follow the opcode
  always_ff @(posedge tck_in or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      drive_reg <= 1'b0;
      hiz_reg <= 1'b0;
    end
    else
    begin
      drive_reg <= ir_reg == `JTB_OP_EXTEST || ir_reg == `JTB_OP_CLAMP;
      hiz_reg <= ir_reg == `JTB_OP_HIGHZ;
    end
  end

  // pin state capture, two stages from the system domain
  always_ff @(posedge tck_in or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      cap_s1_reg <= '0;
      cap_s2_reg <= '0;
    end
    else
    begin
      cap_s1_reg <= pin_view;
      cap_s2_reg <= cap_s1_reg;
    end
  end

  // bypass and identification shifters
  always_ff @(posedge tck_in or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      byp_reg <= 1'b0;
      id_reg <= '0;
    end
    else if (st_reg == JTB_CDR)
    begin
      byp_reg <= 1'b0;
      if (ir_reg == `JTB_OP_USERCODE)
        id_reg <= USER_CODE;
      else
        id_reg <= {ID_VER, ID_PART, ID_MFR, `JTB_ID_LSB};
    end
    else if (st_reg == JTB_SHDR)
    begin
      byp_reg <= pin.tdi;
      id_reg <= {pin.tdi, id_reg[`JTB_ID_W-1:1]};
    end
  end

  // boundary chain: capture, shift from tdi end, update
  always_ff @(posedge tck_in or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      bsr_reg <= '0;
      upd_reg <= '0;
      upd_tog_reg <= 1'b0;
    end
    else if (dr_sel == JTB_DR_BSR)
    begin
      if (st_reg == JTB_CDR)
        bsr_reg <= cap_s2_reg;
      else if (st_reg == JTB_SHDR)
        bsr_reg <= {pin.tdi, bsr_reg[NC-1:1]};
      else if (st_reg == JTB_UDR)
      begin
        upd_reg <= bsr_reg;
        upd_tog_reg <= !upd_tog_reg;
      end
    end
  end

  // tdo on falling tck, driven only while shifting
  always_ff @(negedge tck_in or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      tdo_out <= 1'b0;
      tdo_oe_out <= 1'b0;
    end
    else
    begin
      tdo_oe_out <= st_reg == JTB_SHDR || st_reg == JTB_SHIR;
      if (st_reg == JTB_SHIR)
        tdo_out <= ir_sh_reg[0];
      else
        case (dr_sel)
          JTB_DR_BSR: tdo_out <= bsr_reg[0];
          JTB_DR_ID: tdo_out <= id_reg[0];
          default: tdo_out <= byp_reg;
        endcase
    end
  end

  // ****************************************
  // system domain
  // ****************************************
  logic [1:0] prog_sync_reg; // programmed level sync
  logic [N_IO-1:0] pin_s1_reg; // pad input, first stage
  logic [N_IO-1:0] pin_s2_reg; // pad input, second stage
  logic [1:0] drive_sync_reg; // drive flag sync
  logic [1:0] hiz_sync_reg; // highz flag sync
  logic [2:0] tog_sync_reg; // update toggle sync plus edge
  logic pend_reg; // update word waiting for fifo
  logic [NC-1:0] live_reg; // applied update word
  logic fifo_ready; // fifo accepts
  logic io_en; // global i/o enable
  logic [N_IO-1:0] live_out; // update latches, output cells
  logic [N_IO-1:0] live_oe; // update latches, enable cells

  assign io_en = prog_sync_reg[1];

  // synchronisers for async levels
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      prog_sync_reg <= '0;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      drive_sync_reg <= '0;
      hiz_sync_reg <= '0;
      tog_sync_reg <= '0;
    end
    else
    begin
      prog_sync_reg <= {prog_sync_reg[0], programmed_in};
      pin_s1_reg <= pad_in;
      pin_s2_reg <= pin_s1_reg;
      drive_sync_reg <= {drive_sync_reg[0], drive_reg};
      hiz_sync_reg <= {hiz_sync_reg[0], hiz_reg};
      tog_sync_reg <= {tog_sync_reg[1:0], upd_tog_reg};
    end
  end

  // update word taken once fifo has room; stalls while full
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pend_reg <= 1'b0;
      live_reg <= '0;
    end
    else
    begin
      if (tog_sync_reg[2] != tog_sync_reg[1])
        pend_reg <= 1'b1; // new update beats the clear
      else if (pend_reg && fifo_ready)
        pend_reg <= 1'b0;
      if (pend_reg && fifo_ready)
        live_reg <= upd_reg; // stable since toggle
    end
  end

  // per-i/o cell wiring
  for (genvar i = 0; i < N_IO; i++)
  begin : g_io
    assign live_out[i] = live_reg[`JTB_CELLS*i+`JTB_CELL_OUT];
    assign live_oe[i] = live_reg[`JTB_CELLS*i+`JTB_CELL_OE];
    assign pin_view[`JTB_CELLS*i+`JTB_CELL_IN] = core_in_out[i];
    assign pin_view[`JTB_CELLS*i+`JTB_CELL_OUT] = pad_out[i];
    assign pin_view[`JTB_CELLS*i+`JTB_CELL_OE] = pad_oe_out[i];
  end

  // pad buffers: core or update latches, gated by io enable
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pad_out <= '0;
      pad_oe_out <= '0;
      core_in_out <= '0;
    end
    else
    begin
      core_in_out <= io_en ? pin_s2_reg : '0;
      pad_out <= drive_sync_reg[1] ? live_out : core_out_in;
      if (!io_en || hiz_sync_reg[1])
        pad_oe_out <= '0;
      else
        pad_oe_out <= drive_sync_reg[1] ? live_oe : core_oe_in;
    end
  end

  // log of applied update words: output and enable per i/o
  jtb_fifo #(
    .W(2*N_IO),
    .D(`JTB_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_sys_in),
    .rst_in(sys_rst_in),
    .in_valid_in(pend_reg),
    .in_ready_out(fifo_ready),
    .in_data_in({live_oe_w(upd_reg), live_out_w(upd_reg)}),
    .out_valid_out(obs_valid_out),
    .out_ready_in(obs_ready_in),
    .out_data_out(obs_data_out)
  );

  // pick output cells of a chain word
  function automatic logic [N_IO-1:0] live_out_w(input logic [NC-1:0] w);
    for (int k = 0; k < N_IO; k++)
      live_out_w[k] = w[`JTB_CELLS*k+`JTB_CELL_OUT];
  endfunction

  // pick enable cells of a chain word
  function automatic logic [N_IO-1:0] live_oe_w(input logic [NC-1:0] w);
    for (int k = 0; k < N_IO; k++)
      live_oe_w[k] = w[`JTB_CELLS*k+`JTB_CELL_OE];
  endfunction
endmodule

/* File: dv/jtb_tap_chk.sv */
// checker for the tap top: pad gating, tdo timing, update stream
// assumes binding onto every jtb_tap instance
`timescale 1ns/1ns
// ****************
// checker
// ****************
module jtb_tap_chk #(
  parameter int N_IO = 4
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic tck_in,
  input wire jtb_pkg::jtb_jtag_s jtag_in,
  input wire jtb_pkg::jtb_jtag_s jtag_float_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  input wire logic programmed_in,
  input wire logic [N_IO-1:0] pad_oe_out,
  input wire logic [N_IO-1:0] core_in_out,
  input wire logic obs_valid_out,
  input wire logic obs_ready_in,
  input wire logic [2*N_IO-1:0] obs_data_out
);
  import jtb_pkg::*;
  logic trst_low; // test reset seen low at the pin
  assign trst_low = !jtag_in.trst_n && !jtag_float_in.trst_n;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // device held unprogrammed past the sync delay
  sequence unprog_s;
    !programmed_in [*4];
  endsequence
  // tck high on two samples: no falling edge in between
  sequence tck_hi_s;
    tck_in ##1 tck_in;
  endsequence
  unprog_oe_a: assert property (unprog_s |=> pad_oe_out == '0)
    else $error("pad enabled while unprogrammed");
  unprog_core_a: assert property (unprog_s |=> core_in_out == '0)
    else $error("input buffer open while unprogrammed");
  tdo_quiet_a: assert property (tck_hi_s |-> $stable(tdo_out))
    else $error("tdo moved while tck high");
  oe_quiet_a: assert property (tck_hi_s |-> $stable(tdo_oe_out))
    else $error("tdo enable moved while tck high");
  oe_rise_a: assert property ($rose(tdo_oe_out) |-> !tck_in)
    else $error("tdo enable rose outside falling tck");
  trst_oe_a: assert property (trst_low [*2] |-> !tdo_oe_out)
    else $error("tdo driven during test reset");
  obs_hold_a: assert property (
    obs_valid_out && !obs_ready_in |=> obs_valid_out && $stable(obs_data_out))
    else $error("stalled update word dropped or changed");
  reset_empty_a: assert property ($fell(sys_rst_in) |-> !obs_valid_out)
    else $error("update stream not empty after reset");
endmodule
bind jtb_tap jtb_tap_chk #(.N_IO(N_IO)) u_chk (.clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in), .tck_in(tck_in), .jtag_in(jtag_in),
  .jtag_float_in(jtag_float_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
  .programmed_in(programmed_in), .pad_oe_out(pad_oe_out),
  .core_in_out(core_in_out), .obs_valid_out(obs_valid_out),
  .obs_ready_in(obs_ready_in), .obs_data_out(obs_data_out));

/* File: dv/jtb_ctl.sv */
// external test controller model driving tck, tms, tdi and trst
// assumes tck stands low between frames, period 125 ns
`timescale 1ns/1ns
// ****************
// controller
// ****************
module jtb_ctl (
  output logic tck_out,
  output jtb_pkg::jtb_jtag_s jtag_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  import jtb_pkg::*;
  logic tdo_s; // tdo seen at the last rising tck
  logic oe_s; // tdo enable seen there
  initial
  begin
    tck_out = 1'b0;
    jtag_out = '{tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
  end
  // one tck period; tms and tdi settle while tck is low
  task automatic tick(input logic tms, input logic tdi);
    jtag_out.tms = tms;
    jtag_out.tdi = tdi;
    #62;
    tdo_s = tdo_oe_in ? tdo_in : ~tdo_in; // released tdo reads inverted
    oe_s = tdo_oe_in;
    tck_out = 1'b1;
    #63;
    tck_out = 1'b0;
  endtask
  // five tms-high edges, then on to run-test-idle
  task automatic reset5();
    repeat (5) tick(1'b1, ~jtag_out.tdi);
    tick(1'b0, ~jtag_out.tdi);
  endtask
  // async test reset pulse with tck still
  task automatic trst_pulse();
    jtag_out.trst_n = 1'b0;
    #200;
    jtag_out.trst_n = 1'b1;
    #60;
    tick(1'b0, ~jtag_out.tdi);
  endtask
  // ir or dr scan from run-test-idle back to run-test-idle
  task automatic scan(input logic ir, input int len, input logic [31:0] din,
    output logic [31:0] dout, output logic oe_ok);
    dout = '0;
    oe_ok = 1'b1;
    tick(1'b1, ~jtag_out.tdi);
    if (ir)
      tick(1'b1, ~jtag_out.tdi);
    tick(1'b0, ~jtag_out.tdi);
    tick(1'b0, ~jtag_out.tdi);
    for (int i = 0; i < len; i++)
    begin
      tick(i == len - 1, din[i]);
      dout[i] = tdo_s;
      oe_ok = oe_ok & oe_s;
    end
    tick(1'b1, ~jtag_out.tdi);
    tick(1'b0, ~jtag_out.tdi);
  endtask
endmodule

/* File: dv/jtb_tap_tb.sv */
// self-checking bench for the tap top
// assumes jtb_ctl as the test controller on the jtag side
`timescale 1ns/1ns
// ****************
// bench
// ****************
module jtb_tap_tb;
  import jtb_pkg::*;
  localparam logic [10:0] MFR = 11'h2b1; // arbitrary
  localparam logic [15:0] PRT = 16'h5a3c; // arbitrary
  localparam logic [3:0] VER = 4'h3; // arbitrary
  localparam logic [31:0] UCODE = 32'h1234_abcd; // arbitrary
  localparam logic [31:0] IDW = {VER, PRT, MFR, 1'b1};
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic tck, tdo, tdo_oe, obs_valid, ok;
  logic programmed = 1'b0;
  logic obs_ready = 1'b0;
  logic hold_rdy = 1'b0; // consumer stalls while set
  jtb_jtag_s jtag;
  jtb_jtag_s flt = '0; // undriven jtag pins
  logic [3:0] pad_in = '0, core_out = '0, core_oe = '0;
  logic [3:0] pad_out, pad_oe, core_in;
  logic [7:0] obs_data;
  logic [7:0] ops [4] = '{8'hff, 8'h3c, 8'h0e, 8'h0f};
  logic [7:0] expq [$]; // expected update words
  logic [31:0] r, got, e;
  int err_count = 0;
  int n_checks = 0;
  jtb_tap #(.N_IO(4), .ID_MFR(MFR), .ID_PART(PRT), .ID_VER(VER),
    .USER_CODE(UCODE)) uut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .tck_in(tck), .jtag_in(jtag), .jtag_float_in(flt), .tdo_out(tdo),
    .tdo_oe_out(tdo_oe), .programmed_in(programmed), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_out(pad_oe), .core_in_out(core_in),
    .core_out_in(core_out), .core_oe_in(core_oe), .obs_valid_out(obs_valid),
    .obs_ready_in(obs_ready), .obs_data_out(obs_data));
  jtb_ctl u_ctl (.tck_out(tck), .jtag_out(jtag), .tdo_in(tdo),
    .tdo_oe_in(tdo_oe));
  initial forever #2 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] g);
    n_checks++;
    if (g !== ex)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, ex, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // update word a boundary load should push: {enables, outputs}
  function automatic logic [7:0] upd(input logic [31:0] p);
    logic [7:0] w;
    for (int i = 0; i < 4; i++)
      w[i] = p[3*i+1];
    for (int i = 0; i < 4; i++)
      w[4+i] = p[3*i+2];
    return w;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic ir(input logic [7:0] op);
    u_ctl.scan(1'b1, 8, {24'h0, op}, got, ok);
  endtask
  // boundary scan with the expected update word noted first
  task automatic bsr();
    r = $urandom();
    expq.push_back(upd(r));
    u_ctl.scan(1'b0, 12, {20'h0, r[11:0]}, got, ok);
  endtask
  task automatic drain();
    hold_rdy = 1'b0;
    for (int i = 0; i < 5000 && expq.size() != 0; i++)
      step(1);
    chk("stream drained", 0, expq.size());
  endtask
  // consumer: compares each accepted word, stalls at random
  always @(posedge clk_sys_in)
  begin
    if (obs_valid === 1'b1 && obs_ready === 1'b1)
      chk("obs word", expq.size() ? expq.pop_front() : 8'hxx, obs_data);
    obs_ready <= #1 hold_rdy ? 1'b0 : 1'($urandom_range(1));
  end
  initial
  begin
    step(100000);
    chk("timeout", 0, 1);
    stop_test();
  end
  initial
  begin
    void'($urandom(32'h29ae));
    step(6);
    sys_rst_in = 1'b0;
    u_ctl.tick(1'b0, 1'b0);
    u_ctl.scan(1'b0, 32, $urandom(), got, ok);
    chk("idcode at reset", IDW, got);
    chk("tdo enable in shift", 1, ok);
    chk("tdo enable idle", 0, tdo_oe);
    $display("test id done");
    foreach (ops[k])
    begin
      ir(ops[k]);
      chk("ir capture", 32'h01, got);
      r = $urandom();
      u_ctl.scan(1'b0, 32, r, got, ok);
      e = ops[k] == 8'h0e ? UCODE : ops[k] == 8'h0f ? IDW : {r[30:0], 1'b0};
      chk("dr by opcode", e, got);
    end
    $display("test opcodes done");
    for (int m = 0; m < 3; m++)
    begin
      ir(8'hff);
      if (m == 0)
      begin
        u_ctl.tick(1'b1, 1'b0);
        u_ctl.tick(1'b0, 1'b0);
        u_ctl.tick(1'b1, 1'b0);
        u_ctl.tick(1'b0, 1'b0);
        u_ctl.reset5();
      end
      else if (m == 1)
        u_ctl.trst_pulse();
      else
      begin
        flt.tms = 1'b1;
        repeat (5) u_ctl.tick(1'b0, 1'b0);
        flt.tms = 1'b0;
        u_ctl.tick(1'b0, 1'b0);
      end
      u_ctl.scan(1'b0, 32, $urandom(), got, ok);
      chk("idcode after reset path", IDW, got);
    end
    $display("test resets done");
    step(1);
    programmed = 1'b1;
    {pad_in, core_out, core_oe} = 12'($urandom());
    step(10);
    ir(8'h01);
    for (int i = 0; i < 4; i++)
      e[3*i +: 3] = {core_oe[i], core_out[i], pad_in[i]};
    bsr();
    chk("sample capture", {20'h0, e[11:0]}, got);
    ir(8'h00);
    bsr();
    chk("extest outputs", upd(r), {pad_oe, pad_out});
    ir(8'h05);
    u_ctl.tick(1'b0, 1'b0);
    chk("clamp enables", upd(r) >> 4, pad_oe);
    ir(8'h07);
    u_ctl.tick(1'b0, 1'b0);
    chk("highz enables", 0, pad_oe);
    drain();
    $display("test pins done");
    ir(8'h01);
    hold_rdy = 1'b1;
    repeat (17) bsr();
    drain();
    chk("stream empty", 0, obs_valid);
    $display("test fifo done");
    step(1);
    programmed = 1'b0;
    step(10);
    bsr();
    chk("unprogrammed inputs", 0, got & 32'h249);
    chk("unprogrammed enables", 0, pad_oe);
    drain();
    $display("test unprogrammed done");
    stop_test();
  end
endmodule
